// ==== verilog/cpttt_top.sv ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cpttt_top
    import cpttt_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        halt_wake,
    output logic             cpu_clk_en,
    output logic             clock_out_pin_o,
    output logic             clock_out_pin_oe,
    output logic             tone_pin_o,
    output logic             tone_pin_oe,
    output logic             tick_irq
);
    typedef struct packed {
        logic       aw_got;
        logic [7:0] aw_addr;
        logic       w_got;
        logic [7:0] w_data;
        logic       w_lane0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ccs;
        logic [1:0] tone_sel;
        logic       gmask;
        cpttt_pwr_t pwr;
        logic [3:0] div_cnt;
        logic       cpu_en;
        logic       clk_out;
        logic       clk_oe;
        logic       tone_o;
        logic       tone_oe;
        logic       irq;
        logic [1:0] wake_sync;
    } cpttt_st_t;

    cpttt_st_t s_r, s_nxt;
    cpttt_regs_if rif ();

    // divide ratio minus one for slow mode
    function automatic logic [3:0] presc_max(input logic [1:0] cp);
        case (cp)
            2'b00:   presc_max = 4'h1;
            2'b01:   presc_max = 4'h3;
            2'b10:   presc_max = 4'h7;
            default: presc_max = 4'hF;
        endcase
    endfunction

    logic wr_fire;
    logic rd_fire;
    logic tick_now;
    logic wake_pin;

    assign tick_now = rif.tick_pulse;
    assign wake_pin = s_r.wake_sync[1];
    assign wr_fire  = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    assign rd_fire  = s_axi_arvalid && s_axi_arready;

    assign rif.ccs      = s_r.ccs;
    assign rif.tone_sel = s_r.tone_sel;
    assign rif.frozen   = (s_r.pwr == CPTTT_HALT);
    assign rif.lowpow   = (s_r.pwr == CPTTT_TICKHALT);

    always_comb begin
        s_nxt = s_r;
        // halt_wake is an outside level; two stages before use
        s_nxt.wake_sync = {s_r.wake_sync[0], halt_wake};

        // write channel capture, either order
        // capture only on the handshake, so a held valid is never taken twice
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_got   = 1'b1;
            s_nxt.w_data  = s_axi_wdata[7:0];
            s_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // tick flag set from counter; set beats read clear
        if (rd_fire && s_axi_araddr == CPTTT_ADDR_CLK_CTRL_STATUS) begin
            s_nxt.ccs[CPTTT_BIT_TICK_FLAG] = 1'b0;
        end
        if (tick_now) begin
            s_nxt.ccs[CPTTT_BIT_TICK_FLAG] = 1'b1;
        end

        // clock_ctrl_status and tone select writes blocked in full halt; power_ctrl still written
        if (wr_fire) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = CPTTT_RESP_OKAY;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            if (s_r.aw_addr == CPTTT_ADDR_CLK_CTRL_STATUS) begin
                if (s_r.w_lane0 && s_r.pwr != CPTTT_HALT) begin
                    s_nxt.ccs[7:1] = s_r.w_data[7:1];
                end
            end else if (s_r.aw_addr == CPTTT_ADDR_TONE_CTRL) begin
                // upper bits kept zero; software should write zeros there
                if (s_r.w_lane0 && s_r.pwr != CPTTT_HALT) begin
                    s_nxt.tone_sel = s_r.w_data[1:0];
                end
            end else if (s_r.aw_addr == CPTTT_ADDR_POWER_CTRL) begin
                if (s_r.w_lane0) begin
                    s_nxt.gmask = s_r.w_data[CPTTT_BIT_GMASK];
                    if (s_r.w_data[CPTTT_BIT_HALT_REQ] && s_r.pwr == CPTTT_RUN) begin
                        // enable chooses tick-halt over full halt
                        s_nxt.pwr = s_r.ccs[CPTTT_BIT_TICK_IE] ? CPTTT_TICKHALT
                                                                : CPTTT_HALT;
                    end
                end
            end else if (s_r.aw_addr != CPTTT_ADDR_POWER_STATUS) begin
                s_nxt.bresp = CPTTT_RESP_SLVERR;
            end
        end

        // reads
        if (rd_fire) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = CPTTT_RESP_OKAY;
            s_nxt.rdata  = '0;
            if (s_axi_araddr == CPTTT_ADDR_CLK_CTRL_STATUS) begin
                s_nxt.rdata[7:0] = s_r.ccs;
            end else if (s_axi_araddr == CPTTT_ADDR_TONE_CTRL) begin
                s_nxt.rdata[1:0] = s_r.tone_sel;
            end else if (s_axi_araddr == CPTTT_ADDR_POWER_CTRL) begin
                s_nxt.rdata[CPTTT_BIT_GMASK] = s_r.gmask;
            end else if (s_axi_araddr == CPTTT_ADDR_POWER_STATUS) begin
                s_nxt.rdata[1:0] = s_r.pwr;
            end else begin
                s_nxt.rresp = CPTTT_RESP_SLVERR;
            end
        end

        // wake-ups: tick irq wakes only tick-halt
        if (s_r.pwr == CPTTT_TICKHALT && s_r.ccs[CPTTT_BIT_TICK_IE]
            && s_r.ccs[CPTTT_BIT_TICK_FLAG]) begin
            s_nxt.pwr = CPTTT_RUN;
        end
        if (s_r.pwr != CPTTT_RUN && wake_pin) begin
            s_nxt.pwr = CPTTT_RUN;
        end

        // cpu clock enable: every cycle or one in 2..16
        if (!s_r.ccs[CPTTT_BIT_SLOW]) begin
            s_nxt.div_cnt = '0;
            s_nxt.cpu_en  = 1'b1;
        end else if (s_r.div_cnt >= presc_max(s_r.ccs[CPTTT_BIT_PRESC_HI:CPTTT_BIT_PRESC_LO])) begin
            s_nxt.div_cnt = '0;
            s_nxt.cpu_en  = 1'b1;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 4'h1;
            s_nxt.cpu_en  = 1'b0;
        end
        if (s_r.pwr != CPTTT_RUN) begin
            s_nxt.cpu_en = 1'b0;
        end

        // clock out carries the cpu clock enable as a waveform
        s_nxt.clk_oe  = s_r.ccs[CPTTT_BIT_CLK_OUT];
        s_nxt.clk_out = s_r.ccs[CPTTT_BIT_CLK_OUT] && s_r.pwr == CPTTT_RUN
                        && s_nxt.cpu_en;

        s_nxt.tone_o  = rif.tone_out;
        s_nxt.tone_oe = (s_r.tone_sel != 2'b00);

        // interrupt gated by flag, enable, global mask
        s_nxt.irq = s_r.ccs[CPTTT_BIT_TICK_FLAG] && s_r.ccs[CPTTT_BIT_TICK_IE]
                    && !s_r.gmask;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.ccs      <= CPTTT_CCS_RESET;
            s_r.tone_sel <= CPTTT_TONE_RESET[1:0];
            s_r.pwr      <= CPTTT_RUN;
            s_r.cpu_en   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    cpttt_tickgen u_tickgen (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rif     (rif.gen)
    );

    // ready while slot empty; aw/w taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !s_nxt.aw_got;
            s_axi_wready  <= !s_nxt.w_got;
            s_axi_arready <= !s_nxt.rvalid;
        end
    end

    assign s_axi_bvalid     = s_r.bvalid;
    assign s_axi_bresp      = s_r.bresp;
    assign s_axi_rvalid     = s_r.rvalid;
    assign s_axi_rdata      = s_r.rdata;
    assign s_axi_rresp      = s_r.rresp;
    assign cpu_clk_en       = s_r.cpu_en;
    assign clock_out_pin_o  = s_r.clk_out;
    assign clock_out_pin_oe = s_r.clk_oe;
    assign tone_pin_o       = s_r.tone_o;
    assign tone_pin_oe      = s_r.tone_oe;
    assign tick_irq         = s_r.irq;
endmodule // cpttt_top
`default_nettype wire

// ==== verilog/cpttt_pkg.sv ====
package cpttt_pkg;
    // register byte addresses on the AXI4-Lite slave
    // printed offsets are word indexes; byte address is four times the index
    localparam logic [7:0] CPTTT_IDX_CLK_CTRL_STATUS  = 8'h2C;
    localparam logic [7:0] CPTTT_IDX_TONE_CTRL        = 8'h2D;
    localparam logic [7:0] CPTTT_ADDR_CLK_CTRL_STATUS = CPTTT_IDX_CLK_CTRL_STATUS << 2;
    localparam logic [7:0] CPTTT_ADDR_TONE_CTRL       = CPTTT_IDX_TONE_CTRL << 2;
    // own registers: power-state control and status
    localparam logic [7:0] CPTTT_ADDR_POWER_CTRL      = 8'h30;
    localparam logic [7:0] CPTTT_ADDR_POWER_STATUS    = 8'h34;
    localparam int         CPTTT_ADDR_W               = 8;

    localparam logic [7:0] CPTTT_CCS_RESET  = 8'h00;
    localparam logic [7:0] CPTTT_TONE_RESET = 8'h00;

    // clock_ctrl_status field positions
    localparam int CPTTT_BIT_CLK_OUT   = 7;
    localparam int CPTTT_BIT_PRESC_HI  = 6;
    localparam int CPTTT_BIT_PRESC_LO  = 5;
    localparam int CPTTT_BIT_SLOW      = 4;
    localparam int CPTTT_BIT_TB_HI     = 3;
    localparam int CPTTT_BIT_TB_LO     = 2;
    localparam int CPTTT_BIT_TICK_IE   = 1;
    localparam int CPTTT_BIT_TICK_FLAG = 0;

    // power_ctrl bits
    localparam int CPTTT_BIT_HALT_REQ  = 0;
    localparam int CPTTT_BIT_GMASK     = 1;

    // tick periods in osc_clock cycles
    localparam logic [17:0] CPTTT_TICK_P0 = 18'd16000;
    localparam logic [17:0] CPTTT_TICK_P1 = 18'd32000;
    localparam logic [17:0] CPTTT_TICK_P2 = 18'd80000;
    localparam logic [17:0] CPTTT_TICK_P3 = 18'd200000;

    // tone half periods at 8 MHz: 2 kHz, 1 kHz, 500 Hz
    localparam logic [13:0] CPTTT_TONE_H1 = 14'd2000;
    localparam logic [13:0] CPTTT_TONE_H2 = 14'd4000;
    localparam logic [13:0] CPTTT_TONE_H3 = 14'd8000;

    localparam logic [1:0] CPTTT_RESP_OKAY   = 2'b00;
    localparam logic [1:0] CPTTT_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CPTTT_RUN      = 2'b00,
        CPTTT_TICKHALT = 2'b01,
        CPTTT_HALT     = 2'b10
    } cpttt_pwr_t;
endpackage

// ==== verilog/cpttt_regs_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface cpttt_regs_if;
    logic [7:0] ccs;
    logic [1:0] tone_sel;
    logic       frozen;
    logic       lowpow;
    logic       tick_pulse;
    logic       tone_out;
    modport core (output ccs, output tone_sel, output frozen, output lowpow,
                  input tick_pulse, input tone_out);
    modport gen (input ccs, input tone_sel, input frozen, input lowpow,
                 output tick_pulse, output tone_out);
endinterface
`default_nettype wire

// ==== verilog/cpttt_tickgen.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpttt_tickgen
    import cpttt_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    cpttt_regs_if.gen   rif
);
    typedef struct packed {
        logic [17:0] tick_cnt;
        logic [17:0] period;
        logic [13:0] tone_cnt;
        logic        tone;
        logic        tick;
    } cpttt_tg_t;

    cpttt_tg_t s_r, s_nxt;

    function automatic logic [17:0] tb_period(input logic [1:0] tb);
        case (tb)
            2'b00:   tb_period = CPTTT_TICK_P0;
            2'b01:   tb_period = CPTTT_TICK_P1;
            2'b10:   tb_period = CPTTT_TICK_P2;
            default: tb_period = CPTTT_TICK_P3;
        endcase
    endfunction

    function automatic logic [13:0] tone_half(input logic [1:0] sel);
        case (sel)
            2'b01:   tone_half = CPTTT_TONE_H1;
            2'b10:   tone_half = CPTTT_TONE_H2;
            default: tone_half = CPTTT_TONE_H3;
        endcase
    endfunction

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (!rif.frozen) begin // counter frozen in full halt
            if (s_r.tick_cnt + 18'd1 >= s_r.period) begin
                s_nxt.tick_cnt = '0;
                s_nxt.tick     = 1'b1;
                // new time base only at period end
                s_nxt.period   = tb_period(rif.ccs[CPTTT_BIT_TB_HI:CPTTT_BIT_TB_LO]);
            end else begin
                s_nxt.tick_cnt = s_r.tick_cnt + 18'd1;
            end
        end
        // tone keeps running in low-power tick state
        if (rif.tone_sel == 2'b00 || rif.frozen) begin
            s_nxt.tone_cnt = '0;
            s_nxt.tone     = 1'b0;
        end else if (s_r.tone_cnt + 14'd1 >= tone_half(rif.tone_sel)) begin
            s_nxt.tone_cnt = '0;
            s_nxt.tone     = ~s_r.tone;
        end else begin
            s_nxt.tone_cnt = s_r.tone_cnt + 14'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.period   <= CPTTT_TICK_P0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rif.tick_pulse = s_r.tick;
    assign rif.tone_out   = s_r.tone;
endmodule // cpttt_tickgen
`default_nettype wire

// ==== testbench/cpttt_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpttt_chk
    import cpttt_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        cpu_clk_en,
    input wire logic        clock_out_pin_o,
    input wire logic        clock_out_pin_oe,
    input wire logic        tone_pin_o,
    input wire logic        tone_pin_oe,
    input wire logic        tick_irq
);
    logic [13:0] tcnt_r;
    logic [4:0]  lcnt_r;
    logic        tprev_r;
    // cycles since last tone edge, and length of the cpu clock gap
    always_ff @(posedge aclk) begin
        tprev_r <= tone_pin_o;
        tcnt_r  <= (!tone_pin_oe || tone_pin_o != tprev_r) ? 14'h0000 : tcnt_r + 14'h0001;
        lcnt_r  <= (cpu_clk_en || !aresetn) ? 5'h00 : lcnt_r + {4'h0, lcnt_r != 5'h1f};
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_clkout_oe: assert property (clock_out_pin_o |-> clock_out_pin_oe)
        else $error("clock out driven while disabled");
    // a gap over 17 cycles is longer than any slow-mode gap, so a halt state
    a_halt_noclk: assert property (lcnt_r > 5'h11 && !cpu_clk_en |-> !clock_out_pin_o)
        else $error("clock out runs during halt");
    a_tone_oe: assert property (tone_pin_o |-> tone_pin_oe)
        else $error("tone driven while off");
    a_tone_runs: assert property (tone_pin_oe |-> tcnt_r <= CPTTT_TONE_H3)
        else $error("tone stalled");
    a_read_clears: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == CPTTT_ADDR_CLK_CTRL_STATUS |-> ##[1:4] !tick_irq)
        else $error("status read left request up");
    a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    c_tick: cover property ($rose(tick_irq));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == CPTTT_RESP_SLVERR);
    c_tone: cover property (tone_pin_oe && tone_pin_o != tprev_r);
endmodule // cpttt_chk
bind cpttt_top cpttt_chk u_chk (.*);
`default_nettype wire

// ==== testbench/cpttt_pin_load.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpttt_pin_load (
    input  wire logic pin_o,
    input  wire logic pin_oe,
    input  wire logic aclk,
    output logic      pin_lvl,
    output int        half_len
);
    logic last_r = 1'b0;
    int   cnt    = 0;
    // released pin must not look like a held value
    assign pin_lvl = pin_oe ? pin_o : !last_r;
    always @(posedge aclk) begin
        cnt <= cnt + 1;
        if (pin_oe) begin
            last_r <= pin_o;
            if (pin_o != last_r) begin
                half_len <= cnt;
                cnt      <= 1;
            end
        end
    end
endmodule // cpttt_pin_load
`default_nettype wire

// ==== testbench/cpttt_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpttt_tb;
    import cpttt_pkg::*;
    localparam logic [7:0] CCS = CPTTT_ADDR_CLK_CTRL_STATUS;
    localparam logic [7:0] PWC = CPTTT_ADDR_POWER_CTRL;
    localparam logic [7:0] PWS = CPTTT_ADDR_POWER_STATUS;
    logic aclk = 1'b0, aresetn = 1'b0, halt_wake = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cpu_clk_en, clock_out_pin_o, clock_out_pin_oe, tone_pin_o, tone_pin_oe, tick_irq;
    logic clk_lvl, tone_lvl;
    int   tone_half;
    int   fails = 0, compares = 0, cyc = 0;
    cpttt_top dut (.*);
    cpttt_pin_load u_clk (.pin_o(clock_out_pin_o), .pin_oe(clock_out_pin_oe), .aclk(aclk),
                          .pin_lvl(clk_lvl), .half_len());
    cpttt_pin_load u_tone (.pin_o(tone_pin_o), .pin_oe(tone_pin_oe), .aclk(aclk),
                           .pin_lvl(tone_lvl), .half_len(tone_half));
    always #25 aclk = ~aclk;
    task automatic results;
        $display("checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // the wall limit sits well above the longest expected run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wake;
        @(posedge aclk);
        halt_wake <= 1'b1;
        repeat (4) @(posedge aclk);
        halt_wake <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(PWS);
    endtask
    task automatic t_regs;
        rd(CCS);
        chk(d, 32'h0000_0000);
        rd(CPTTT_ADDR_TONE_CTRL);
        chk(d, 32'h0000_0000);
        rd(PWS);
        chk(d, 32'h0000_0000);
        wr(CCS, 32'h0000_0063);
        rd(CCS);
        chk(d, 32'h0000_0062);
        wr(CPTTT_ADDR_TONE_CTRL, 32'h0000_0003);
        rd(CPTTT_ADDR_TONE_CTRL);
        chk(d, 32'h0000_0003);
        wr(8'h40, 32'h0000_0001);
        chk(r, CPTTT_RESP_SLVERR);
        rd(8'h40);
        chk({r, d[29:0]}, {CPTTT_RESP_SLVERR, 30'h0000_0000});
    endtask
    task automatic t_slow;
        int n;
        for (int cp = 0; cp < 5; cp++) begin
            wr(CCS, cp < 4 ? 32'h0000_0090 | (32'(cp) << 5) : 32'h0000_0000);
            repeat (8) @(posedge aclk);
            chk(clock_out_pin_oe, cp < 4);
            n = 0;
            repeat (64) begin
                @(posedge aclk);
                n += cpu_clk_en;
            end
            chk(n, cp < 4 ? 64 >> (cp + 1) : 64);
        end
    endtask
    task automatic t_halt;
        wr(CPTTT_ADDR_TONE_CTRL, 32'h0000_0001);
        wr(CCS, 32'h0000_0082);
        rd(CCS);
        wr(PWC, 32'h0000_0001);
        rd(PWS);
        chk(d, 32'h0000_0001);
        repeat (24) @(posedge aclk);
        chk({cpu_clk_en, clk_lvl}, 32'h0000_0000);
        @(tone_pin_o);
        chk(tone_pin_oe, 32'h0000_0001);
        wake();
        chk(d, 32'h0000_0000);
        wr(CCS, 32'h0000_0000);
        wr(PWC, 32'h0000_0001);
        rd(PWS);
        chk(d, 32'h0000_0002);
        wr(CCS, 32'h0000_0080);
        rd(CCS);
        chk(d, 32'h0000_0000);
        wake();
        chk(d, 32'h0000_0000);
    endtask
    task automatic t_tone;
        wr(CPTTT_ADDR_TONE_CTRL, 32'h0000_0000);
        repeat (4) @(posedge aclk);
        chk(tone_pin_oe, 32'h0000_0000);
        for (int s = 1; s < 4; s++) begin
            wr(CPTTT_ADDR_TONE_CTRL, 32'(s));
            repeat (3) @(tone_pin_o);
            repeat (2) @(posedge aclk);
            chk(tone_half, s == 1 ? CPTTT_TONE_H1 : s == 2 ? CPTTT_TONE_H2 : CPTTT_TONE_H3);
        end
    endtask
    task automatic t_tick;
        int t0;
        wr(CCS, 32'h0000_0002);
        rd(CCS);
        wr(PWC, 32'h0000_0001);
        repeat (4) @(posedge aclk);
        do @(posedge aclk); while (!tick_irq);
        t0 = cyc;
        rd(PWS);
        chk(d, 32'h0000_0000);
        wr(CCS, 32'h0000_0006);
        rd(CCS);
        chk(d, 32'h0000_0007);
        repeat (4) @(posedge aclk);
        chk(tick_irq, 32'h0000_0000);
        do @(posedge aclk); while (!tick_irq);
        chk(cyc - t0, CPTTT_TICK_P0);
        wr(PWC, 32'h0000_0002);
        repeat (3) @(posedge aclk);
        chk(tick_irq, 32'h0000_0000);
        rd(CCS);
        chk(d[0], 32'h0000_0001);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_slow();
        t_halt();
        t_tone();
        t_tick();
        results();
    end
endmodule // cpttt_tb
`default_nettype wire
